// >>> hdl/dpm_pkg.sv
// package: register map, field layout and carrier types of the dma performance monitor
// How it works
// - data counter counts monitored data cycles
// - stall counter counts monitored stall cycles
// - max latency is sixteen bits, upper zero
// - max latency saturates, never wraps
// - only counter clear bit or reset zeroes latency
// - every count is one system clock
// - monitor0 read set at 0x804..0x80c
// - monitor0 write set at 0x810..0x818
// - monitor1 read counters at 0x81c, 0x820
// - clear bit write one zeroes, reads zero
// - each monitor follows its selected channel
// - overflow freezes or zeroes the counters
// - disabled monitor holds its values
package dpm_pkg;
    localparam int NumMon = 2;
    localparam logic [11:0] OffControl    = 12'h800;
    localparam logic [11:0] OffM0RdData   = 12'h804;
    localparam logic [11:0] OffM0RdStall  = 12'h808;
    localparam logic [11:0] OffM0RdLat    = 12'h80c;
    localparam logic [11:0] OffM0WrData   = 12'h810;
    localparam logic [11:0] OffM0WrStall  = 12'h814;
    localparam logic [11:0] OffM0WrLat    = 12'h818;
    localparam logic [11:0] OffM1RdData   = 12'h81c;
    localparam logic [11:0] OffM1RdStall  = 12'h820;
    localparam logic [11:0] OffM1RdLat    = 12'h824;
    localparam logic [11:0] OffM1WrData   = 12'h828;
    localparam logic [11:0] OffM1WrStall  = 12'h82c;
    localparam logic [11:0] OffM1WrLat    = 12'h830;
    localparam int EnLsb   = 0;
    localparam int OfLsb   = 4;
    localparam int ClrLsb  = 8;
    localparam int SelLsb0 = 16;
    localparam int SelLsb1 = 24;
    localparam int SelW    = 6;
    localparam logic [31:0] CntMax  = 32'hffff_ffff;
    localparam logic [15:0] LatMax  = 16'hffff;
    localparam logic [31:0] RegZero = 32'h0000_0000;

    typedef struct packed {
        logic data;
        logic stall;
        logic req;
        logic grant;
    } dpm_obs_t;

    typedef struct packed {
        logic [31:0] rdData;
        logic [31:0] rdStall;
        logic [31:0] wrData;
        logic [31:0] wrStall;
        logic [15:0] rdLat;
        logic [15:0] wrLat;
    } dpm_cnt_t;

    typedef struct packed {
        logic [15:0] rd;
        logic [15:0] wr;
    } dpm_wait_t;

    typedef struct packed {
        logic [SelW-1:0] sel;
        logic            of;
        logic            en;
    } dpm_cfg_t;
endpackage

// >>> hdl/dpm_monitor.sv
// module: two-monitor dma performance monitor with register port
//
// Strobed register access was chosen for this implementation.
module dpm_monitor #(
    parameter int NumDma = 8
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [11:0]       regAddr,
    input  wire logic [31:0]       regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic [31:0]            regRdata,
    input  wire dpm_pkg::dpm_obs_t rdObs [NumDma],
    input  wire dpm_pkg::dpm_obs_t wrObs [NumDma]
);
    localparam int IdxW = (NumDma > 1) ? $clog2(NumDma) : 1;

    ////////////////////////////////////////////////////////////////////////////
    // latency step: returns {next wait count, next max latency}
    function automatic logic [31:0] latStep(input logic [15:0] waitCnt,
                                            input logic [15:0] maxLat,
                                            input dpm_pkg::dpm_obs_t o);
        logic [15:0] w;
        logic [15:0] l;
        w = 16'h0000;
        l = maxLat;
        if (o.req && !o.grant) begin
            w = (waitCnt == dpm_pkg::LatMax) ? waitCnt : waitCnt + 16'h0001;
        end else if (o.req && o.grant && (waitCnt > maxLat)) begin
            l = waitCnt;
        end
        return {w, l};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // control register
    dpm_pkg::dpm_cfg_t cfg_q [dpm_pkg::NumMon];
    dpm_pkg::dpm_cfg_t cfg_d [dpm_pkg::NumMon];
    logic              ctrlWr;
    logic [dpm_pkg::NumMon-1:0] clrPulse;

    assign ctrlWr = regWr && (regAddr == dpm_pkg::OffControl);

    always_comb begin
        for (int m = 0; m < dpm_pkg::NumMon; m++) begin
            cfg_d[m] = cfg_q[m];
            clrPulse[m] = ctrlWr && regWdata[dpm_pkg::ClrLsb + m];
            if (ctrlWr) begin
                cfg_d[m].en = regWdata[dpm_pkg::EnLsb + m];
                cfg_d[m].of = regWdata[dpm_pkg::OfLsb + m];
            end
        end
        if (ctrlWr) begin
            cfg_d[0].sel = regWdata[dpm_pkg::SelLsb0 +: dpm_pkg::SelW];
            cfg_d[1].sel = regWdata[dpm_pkg::SelLsb1 +: dpm_pkg::SelW];
        end
    end

    always_ff @(posedge clk) begin
        for (int m = 0; m < dpm_pkg::NumMon; m++) begin
            if (srst) begin
                cfg_q[m] <= '0;
            end else begin
                cfg_q[m] <= cfg_d[m];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // monitor channels, all counting on the system bus clock
    dpm_pkg::dpm_cnt_t  cnt_q  [dpm_pkg::NumMon];
    dpm_pkg::dpm_cnt_t  cnt_d  [dpm_pkg::NumMon];
    dpm_pkg::dpm_wait_t wait_q [dpm_pkg::NumMon];
    dpm_pkg::dpm_wait_t wait_d [dpm_pkg::NumMon];
    logic [dpm_pkg::NumMon-1:0] frozen;

    for (genvar m = 0; m < dpm_pkg::NumMon; m++) begin : gMon
        dpm_pkg::dpm_obs_t r;
        dpm_pkg::dpm_obs_t w;
        logic              selOk;
        logic [IdxW-1:0]   idx;
        logic              wrap;
        logic [31:0]       rdStep;
        logic [31:0]       wrStep;

        assign idx   = cfg_q[m].sel[IdxW-1:0];
        assign selOk = (32'(cfg_q[m].sel) < NumDma);
        assign r     = selOk ? rdObs[idx] : '0;
        assign w     = selOk ? wrObs[idx] : '0;

        assign frozen[m] = cfg_q[m].of && ((cnt_q[m].rdData == dpm_pkg::CntMax)
                        || (cnt_q[m].rdStall == dpm_pkg::CntMax)
                        || (cnt_q[m].wrData == dpm_pkg::CntMax)
                        || (cnt_q[m].wrStall == dpm_pkg::CntMax));
        assign wrap = !cfg_q[m].of && ((r.data && cnt_q[m].rdData == dpm_pkg::CntMax)
                   || (r.stall && cnt_q[m].rdStall == dpm_pkg::CntMax)
                   || (w.data && cnt_q[m].wrData == dpm_pkg::CntMax)
                   || (w.stall && cnt_q[m].wrStall == dpm_pkg::CntMax));
        assign rdStep = latStep(wait_q[m].rd, cnt_q[m].rdLat, r);
        assign wrStep = latStep(wait_q[m].wr, cnt_q[m].wrLat, w);

        always_comb begin
            cnt_d[m]  = cnt_q[m];
            wait_d[m] = wait_q[m];
            if (clrPulse[m]) begin
                cnt_d[m]  = '0;
                wait_d[m] = '0;
            end else if (cfg_q[m].en && !frozen[m]) begin
                if (wrap) begin
                    cnt_d[m].rdData  = dpm_pkg::RegZero;
                    cnt_d[m].rdStall = dpm_pkg::RegZero;
                    cnt_d[m].wrData  = dpm_pkg::RegZero;
                    cnt_d[m].wrStall = dpm_pkg::RegZero;
                end else begin
                    cnt_d[m].rdData  = cnt_q[m].rdData + 32'(r.data);
                    cnt_d[m].rdStall = cnt_q[m].rdStall + 32'(r.stall);
                    cnt_d[m].wrData  = cnt_q[m].wrData + 32'(w.data);
                    cnt_d[m].wrStall = cnt_q[m].wrStall + 32'(w.stall);
                end
                wait_d[m].rd    = rdStep[31:16];
                cnt_d[m].rdLat  = rdStep[15:0];
                wait_d[m].wr    = wrStep[31:16];
                cnt_d[m].wrLat  = wrStep[15:0];
            end
        end

        always_ff @(posedge clk) begin
            if (srst) begin
                cnt_q[m]  <= '0;
                wait_q[m] <= '0;
            end else begin
                cnt_q[m]  <= cnt_d[m];
                wait_q[m] <= wait_d[m];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port, data one cycle after the strobe
    logic [31:0] rdMux;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    always_comb begin
        unique case (regAddr)
            dpm_pkg::OffControl: begin
                rdMux = dpm_pkg::RegZero;
                rdMux[dpm_pkg::SelLsb1 +: dpm_pkg::SelW] = cfg_q[1].sel;
                rdMux[dpm_pkg::SelLsb0 +: dpm_pkg::SelW] = cfg_q[0].sel;
                rdMux[dpm_pkg::OfLsb + 1] = cfg_q[1].of;
                rdMux[dpm_pkg::OfLsb]     = cfg_q[0].of;
                rdMux[dpm_pkg::EnLsb + 1] = cfg_q[1].en;
                rdMux[dpm_pkg::EnLsb]     = cfg_q[0].en;
            end
            dpm_pkg::OffM0RdData:  rdMux = cnt_q[0].rdData;
            dpm_pkg::OffM0RdStall: rdMux = cnt_q[0].rdStall;
            dpm_pkg::OffM0RdLat:   rdMux = {16'h0000, cnt_q[0].rdLat};
            dpm_pkg::OffM0WrData:  rdMux = cnt_q[0].wrData;
            dpm_pkg::OffM0WrStall: rdMux = cnt_q[0].wrStall;
            dpm_pkg::OffM0WrLat:   rdMux = {16'h0000, cnt_q[0].wrLat};
            dpm_pkg::OffM1RdData:  rdMux = cnt_q[1].rdData;
            dpm_pkg::OffM1RdStall: rdMux = cnt_q[1].rdStall;
            dpm_pkg::OffM1RdLat:   rdMux = {16'h0000, cnt_q[1].rdLat};
            dpm_pkg::OffM1WrData:  rdMux = cnt_q[1].wrData;
            dpm_pkg::OffM1WrStall: rdMux = cnt_q[1].wrStall;
            dpm_pkg::OffM1WrLat:   rdMux = {16'h0000, cnt_q[1].wrLat};
            default:               rdMux = dpm_pkg::RegZero;
        endcase
        rdata_d = regRd ? rdMux : dpm_pkg::RegZero;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign regRdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks on monitor 0
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic live0;
    assign live0 = cfg_q[0].en && !frozen[0] && !clrPulse[0] && !gMon[0].wrap;

    sequence s_clearWrite;
        regWr && (regAddr == dpm_pkg::OffControl) && regWdata[dpm_pkg::ClrLsb];
    endsequence

    sequence s_waitThenGrant;
        live0 && gMon[0].r.req && !gMon[0].r.grant
        ##1 live0 && gMon[0].r.req && gMon[0].r.grant;
    endsequence

    property p_dataCount;
        live0 |=> cnt_q[0].rdData == $past(cnt_q[0].rdData) + 32'($past(gMon[0].r.data));
    endproperty
    a_dataCount: assert property (p_dataCount) else $error("read data count wrong");

    property p_stallCount;
        live0 |=> cnt_q[0].wrStall == $past(cnt_q[0].wrStall) + 32'($past(gMon[0].w.stall));
    endproperty
    a_stallCount: assert property (p_stallCount) else $error("write stall count wrong");

    property p_latHigh;
        regRd && (regAddr == dpm_pkg::OffM0RdLat) |=> regRdata[31:16] == 16'h0000;
    endproperty
    a_latHigh: assert property (p_latHigh) else $error("latency upper bits set");

    property p_latMonotone;
        !clrPulse[0] |=> cnt_q[0].rdLat >= $past(cnt_q[0].rdLat);
    endproperty
    a_latMonotone: assert property (p_latMonotone) else $error("latency dropped");

    property p_clear;
        s_clearWrite |=> cnt_q[0] == '0 && wait_q[0] == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero");

    property p_ctrlRead;
        regRd && (regAddr == dpm_pkg::OffControl) |=> regRdata[9:8] == 2'b00;
    endproperty
    a_ctrlRead: assert property (p_ctrlRead) else $error("clear bits read nonzero");

    property p_readData;
        regRd && (regAddr == dpm_pkg::OffM0RdData) |=> regRdata == $past(cnt_q[0].rdData);
    endproperty
    a_readData: assert property (p_readData) else $error("read data word wrong");

    property p_hold;
        !cfg_q[0].en && !clrPulse[0] |=> $stable(cnt_q[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("disabled monitor moved");

    property p_freeze;
        cfg_q[0].of && cnt_q[0].rdData == dpm_pkg::CntMax && !clrPulse[0] ##1 !clrPulse[0]
            |-> cnt_q[0].rdData == dpm_pkg::CntMax;
    endproperty
    a_freeze: assert property (p_freeze) else $error("frozen counter moved");

    property p_latGrant;
        s_waitThenGrant |=> cnt_q[0].rdLat >= 16'h0001;
    endproperty
    a_latGrant: assert property (p_latGrant) else $error("latency not captured");
endmodule

// >>> verif/dpm_dma_model.sv
// partner model: dma channel bus activity feeding the monitor observation ports
module dpm_dma_model #(
    parameter int NumDma = 8
) (
    input  wire logic [2:0]        cmdCh,
    input  wire dpm_pkg::dpm_obs_t cmdRd,
    input  wire dpm_pkg::dpm_obs_t cmdWr,
    output dpm_pkg::dpm_obs_t      rdObs [NumDma],
    output dpm_pkg::dpm_obs_t      wrObs [NumDma]
);
    timeunit 1ns;
    timeprecision 1ps;
    // only the commanded channel moves, all other channels idle low
    always_comb begin
        for (int i = 0; i < NumDma; i++) begin
            rdObs[i] = (i == int'(cmdCh)) ? cmdRd : 4'h0;
            wrObs[i] = (i == int'(cmdCh)) ? cmdWr : 4'h0;
        end
    end
endmodule

// >>> verif/tb_top.sv
// testbench: register-level checks of the dma performance monitor
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam dpm_pkg::dpm_obs_t Idl = 4'h0;
    localparam dpm_pkg::dpm_obs_t Dat = 4'h8;
    localparam dpm_pkg::dpm_obs_t Stl = 4'h4;
    localparam dpm_pkg::dpm_obs_t Req = 4'h2;
    localparam dpm_pkg::dpm_obs_t Gnt = 4'h3;
    logic              clk;
    logic              srst;
    logic              regWr;
    logic              regRd;
    logic [11:0]       regAddr;
    logic [31:0]       regWdata;
    logic [31:0]       regRdata;
    logic [2:0]        cmdCh;
    dpm_pkg::dpm_obs_t cmdRd;
    dpm_pkg::dpm_obs_t cmdWr;
    dpm_pkg::dpm_obs_t rdObs [8];
    dpm_pkg::dpm_obs_t wrObs [8];
    int                failures;
    int                cmpCount;

    dpm_monitor #(.NumDma(8)) i_dpm_monitor (
        .clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .rdObs(rdObs), .wrObs(wrObs));
    dpm_dma_model #(.NumDma(8)) i_dpm_dma_model (
        .cmdCh(cmdCh), .cmdRd(cmdRd), .cmdWr(cmdWr), .rdObs(rdObs), .wrObs(wrObs));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] got;
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 got = regRdata;
        cmpCount++;
        if (got !== e) begin
            failures++;
            $display("ERROR t=%0t addr %h got %h exp %h", $time, a, got, e);
        end
        @(posedge clk);
    endtask

    // holds the given activity for n cycles; it stays until the next call
    task automatic obs(input logic [2:0] ch, input dpm_pkg::dpm_obs_t r, w, input int n);
        cmdCh <= ch;
        cmdRd <= r;
        cmdWr <= w;
        repeat (n) @(posedge clk);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmpCount, failures);
        if (failures == 0 && cmpCount > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        $display("ERROR t=%0t run limit got %h exp %h", $time, 1'b1, 1'b0);
        tally_and_finish();
    end

    initial begin
        srst = 1'b1; regWr = 1'b0; regRd = 1'b0; regAddr = 12'h000; regWdata = 32'h0000_0000;
        cmdCh = 3'h0; cmdRd = Idl; cmdWr = Idl; failures = 0; cmpCount = 0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 9; i++) chk(12'h800 + 12'(4 * i), 32'h0000_0000);
        chk(12'h900, 32'h0000_0000);
        $display("test reset_values done");
        wr(12'h800, 32'h0003_0001);
        obs(3'h3, Dat, Stl, 5);
        obs(3'h3, Stl, Dat, 2);
        obs(3'h3, Stl, Idl, 1);
        obs(3'h5, Dat, Dat, 4);
        obs(3'h0, Idl, Idl, 1);
        wr(12'h804, 32'h0000_00ff);
        chk(12'h804, 32'h0000_0005);
        chk(12'h808, 32'h0000_0003);
        chk(12'h810, 32'h0000_0002);
        chk(12'h814, 32'h0000_0005);
        $display("test counting done");
        wr(12'h800, 32'h0003_0000);
        obs(3'h3, Dat, Dat, 4);
        obs(3'h0, Idl, Idl, 1);
        chk(12'h804, 32'h0000_0005);
        chk(12'h810, 32'h0000_0002);
        chk(12'h800, 32'h0003_0000);
        $display("test disable done");
        wr(12'h800, 32'h0003_0001);
        obs(3'h3, Req, Req, 2);
        obs(3'h3, Req, Gnt, 1);
        obs(3'h3, Req, Idl, 1);
        obs(3'h3, Gnt, Idl, 1);
        obs(3'h3, Req, Idl, 1);
        obs(3'h3, Gnt, Idl, 1);
        obs(3'h0, Idl, Idl, 1);
        wr(12'h80c, 32'h0000_0000);
        chk(12'h80c, 32'h0000_0004);
        chk(12'h818, 32'h0000_0002);
        chk(12'h804, 32'h0000_0005);
        $display("test latency done");
        wr(12'h800, 32'h0603_0002);
        obs(3'h6, Dat, Idl, 7);
        obs(3'h6, Stl, Idl, 2);
        obs(3'h0, Idl, Idl, 1);
        chk(12'h81c, 32'h0000_0007);
        chk(12'h820, 32'h0000_0002);
        chk(12'h804, 32'h0000_0005);
        $display("test monitor1 done");
        wr(12'h800, 32'h0003_0101);
        for (int i = 0; i < 6; i++) chk(12'h804 + 12'(4 * i), 32'h0000_0000);
        chk(12'h800, 32'h0003_0001);
        chk(12'h81c, 32'h0000_0007);
        $display("test clear done");
        obs(3'h3, Idl, Req, 65540);
        obs(3'h3, Idl, Gnt, 1);
        obs(3'h0, Idl, Idl, 1);
        chk(12'h818, 32'h0000_ffff);
        $display("test saturate done");
        wr(12'h800, 32'h0009_0231);
        obs(3'h1, Dat, Dat, 3);
        obs(3'h0, Idl, Idl, 1);
        chk(12'h804, 32'h0000_0000);
        chk(12'h810, 32'h0000_0000);
        chk(12'h818, 32'h0000_ffff);
        chk(12'h81c, 32'h0000_0000);
        chk(12'h820, 32'h0000_0000);
        chk(12'h800, 32'h0009_0031);
        $display("test select_range done");
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk(12'h818, 32'h0000_0000);
        chk(12'h800, 32'h0000_0000);
        $display("test reset_again done");
        tally_and_finish();
    end
endmodule
